// >>> rtl/nme_core.sv
// Instruction decode and execute unit of the 4-bit nibble processor.
`timescale 1ns/100ps
module nme_core #(
  parameter int CYC_CLKS = nme_pkg::ICYC_CLKS
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Program memory, combinational read.
  output logic [8:0] rom_addr,
  input wire logic [7:0] rom_data,
  // General port, input pins and output latch.
  input wire logic [3:0] gport_in,
  output logic [3:0] gport_out,
  // Byte port with tristate driver.
  input wire logic [7:0] lport_in,
  output logic [7:0] lport_out,
  output logic [7:0] lport_oe,
  // Serial shift/counter data and clock output.
  input wire logic serial_in,
  output logic serial_out,
  output logic clock_out_pin,
  // Status.
  output logic halted
);
  typedef enum logic [1:0] {S_FETCH, S_SECOND, S_IND, S_HALT} nme_state_type;

  initial
  begin
    if (CYC_CLKS < 2)
    begin
      $error("nme_core: CYC_CLKS too small");
    end
  end

  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic tick;
  nme_state_type state_ff;
  nme_state_type nxt_state;
  logic [8:0] program_counter_ff, nxt_pc;
  logic [8:0] return_slot_first_ff, nxt_sa;
  logic [8:0] return_slot_second_ff, nxt_sb;
  logic [3:0] acc_ff, nxt_acc;
  logic carry_ff, nxt_carry;
  logic [1:0] row_pointer_ff, nxt_row;
  logic [3:0] digit_pointer_ff, nxt_digit;
  logic [3:0] en_ff, nxt_en;
  logic [3:0] gpo_ff, nxt_gpo;
  logic [7:0] q_ff, nxt_q;
  logic [3:0] shift_counter_reg_ff, nxt_sio;
  logic clock_out_latch_ff, nxt_skl;
  logic skip_ff, nxt_skip;
  logic lbi_ff, nxt_lbi;
  logic [7:0] op1_ff, nxt_op1;
  logic si_prev_ff, nxt_si_prev;
  logic [3:0] ram_rd;
  logic ram_we;
  logic [5:0] ram_wa, ram_ra;
  logic [3:0] ram_wd;
  logic [4:0] sum;
  logic is_lbi;
  logic two_byte;

  // Instruction cycle enable from the clock divider.
  always_comb
  begin
    tick = (div_ff == 16'(CYC_CLKS - 1));
    nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_ff <= 16'h0000;
    end
    else
    begin
      div_ff <= nxt_div;
    end
  end

  nme_ram #(
    .ROWS(4)
  ) u_ram (
    .clock(clock),
    .wr_en(ram_we),
    .wr_addr(ram_wa),
    .wr_data(ram_wd),
    .rd_addr(ram_ra),
    .rd_data(ram_rd)
  );

  // Pointer immediate is 00rd with low nibble 8..F, excluding the clear-accumulator opcode.
  always_comb
  begin
    is_lbi = (rom_data[7:6] == 2'b00) && (rom_data[3:0] inside {4'hF, 4'h8, 4'h9, 4'hA,
             4'hB, 4'hC, 4'hD, 4'hE}) && !(rom_data == nme_pkg::OP_CLEAR_ACC);
    two_byte = (rom_data == nme_pkg::OP_PFX) || (rom_data == nme_pkg::OP_XAD) ||
               (rom_data[7:4] == nme_pkg::NIB_JMP);
  end

  // Program memory address: indirect table lookup or the program counter.
  always_comb
  begin
    if (state_ff == S_IND)
    begin
      rom_addr = {program_counter_ff[8], acc_ff, ram_rd};
    end
    else
    begin
      rom_addr = program_counter_ff;
    end
  end

  // Decode and execute, one byte per instruction cycle.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pc = program_counter_ff;
    nxt_sa = return_slot_first_ff;
    nxt_sb = return_slot_second_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_row = row_pointer_ff;
    nxt_digit = digit_pointer_ff;
    nxt_en = en_ff;
    nxt_gpo = gpo_ff;
    nxt_q = q_ff;
    nxt_sio = shift_counter_reg_ff;
    nxt_skl = clock_out_latch_ff;
    nxt_skip = skip_ff;
    nxt_lbi = lbi_ff;
    nxt_op1 = op1_ff;
    nxt_si_prev = si_prev_ff;
    ram_we = 1'b0;
    ram_wa = {row_pointer_ff, digit_pointer_ff};
    ram_ra = {row_pointer_ff, digit_pointer_ff};
    ram_wd = 4'h0;
    sum = 5'h00;
    if (state_ff == S_SECOND && op1_ff == nme_pkg::OP_XAD)
    begin
      ram_ra = {nme_pkg::FIX_ROW, nme_pkg::FIX_DIGIT};
      ram_wa = {nme_pkg::FIX_ROW, nme_pkg::FIX_DIGIT};
    end
    // Serial register: counter on falling input, else shifts each cycle.
    if (tick && state_ff != S_HALT)
    begin
      nxt_si_prev = serial_in;
      if (en_ff[0])
      begin
        if (si_prev_ff && !serial_in)
        begin
          nxt_sio = shift_counter_reg_ff - 4'h1;
        end
      end
      else
      begin
        nxt_sio = {shift_counter_reg_ff[2:0], serial_in};
      end
    end
    if (tick)
    begin
      unique case (state_ff)
        S_HALT:
        begin
          nxt_state = S_HALT;
        end
        S_IND:
        begin
          // Second cycle of an indirect instruction.
          if (op1_ff == nme_pkg::OP_IJ)
          begin
            nxt_pc = {program_counter_ff[8], rom_data};
          end
          else
          begin
            nxt_q = rom_data;
            nxt_pc = return_slot_first_ff;
            nxt_sa = return_slot_second_ff;
          end
          nxt_state = S_FETCH;
        end
        S_SECOND:
        begin
          nxt_pc = program_counter_ff + 9'h001;
          nxt_state = S_FETCH;
          if (skip_ff)
          begin
            nxt_skip = 1'b0;
          end
          else if (op1_ff == nme_pkg::OP_XAD)
          begin
            nxt_acc = ram_rd;
            ram_we = 1'b1;
            ram_wd = acc_ff;
          end
          else if (op1_ff[7:4] == nme_pkg::NIB_JMP)
          begin
            nxt_pc = {op1_ff[0], rom_data};
            if (op1_ff[3])
            begin
              nxt_sa = program_counter_ff + 9'h001;
              nxt_sb = return_slot_first_ff;
            end
          end
          else if (rom_data[7:4] == nme_pkg::P2_LEI_HI)
          begin
            nxt_en = rom_data[3:0];
          end
          else
          begin
            unique case (rom_data)
              nme_pkg::P2_HALT: nxt_state = S_HALT;
              nme_pkg::P2_TOQ: nxt_q = {acc_ff, ram_rd};
              nme_pkg::P2_FROMQ:
              begin
                nxt_acc = q_ff[3:0];
                ram_we = 1'b1;
                ram_wd = q_ff[7:4];
              end
              nme_pkg::P2_GZERO: nxt_skip = (gport_in == 4'h0);
              nme_pkg::P2_ING: nxt_acc = gport_in;
              nme_pkg::P2_INL:
              begin
                nxt_acc = lport_in[3:0];
                ram_we = 1'b1;
                ram_wd = lport_in[7:4];
              end
              nme_pkg::P2_OMG: nxt_gpo = ram_rd;
              default: nxt_acc = acc_ff;
            endcase
          end
        end
        S_FETCH:
        begin
          nxt_pc = program_counter_ff + 9'h001;
          nxt_op1 = rom_data;
          nxt_lbi = is_lbi;
          if (skip_ff || (is_lbi && lbi_ff))
          begin
            // Skipped byte; a two-byte op also skips its second byte.
            nxt_skip = two_byte;
            if (two_byte)
            begin
              nxt_state = S_SECOND;
            end
          end
          else if (two_byte)
          begin
            nxt_state = S_SECOND;
          end
          else if (rom_data == nme_pkg::OP_IJ || rom_data == nme_pkg::OP_LQ)
          begin
            nxt_state = S_IND;
            if (rom_data == nme_pkg::OP_LQ)
            begin
              nxt_sa = program_counter_ff + 9'h001;
              nxt_sb = return_slot_first_ff;
            end
          end
          else if (rom_data[7:6] == 2'b11)
          begin
            if (program_counter_ff[8:7] == 2'b01)
            begin
              nxt_pc = {program_counter_ff[8:7], rom_data[6:0]};
            end
            else
            begin
              nxt_pc = {program_counter_ff[8:6], rom_data[5:0]};
            end
          end
          else if (rom_data[7] && program_counter_ff[8:7] == 2'b01)
          begin
            nxt_pc = {program_counter_ff[8:7], rom_data[6:0]};
          end
          else if (rom_data[7:6] == 2'b10)
          begin
            nxt_sa = program_counter_ff + 9'h001;
            nxt_sb = return_slot_first_ff;
            nxt_pc = {nme_pkg::SUBPAGE, rom_data[5:0]};
          end
          else if (rom_data[7:4] == nme_pkg::NIB_ADD_IMM_SKIP)
          begin
            sum = {1'b0, acc_ff} + {1'b0, rom_data[3:0]};
            if (rom_data == nme_pkg::OP_CAB)
            begin
              nxt_digit = acc_ff;
            end
            else
            begin
              nxt_acc = sum[3:0];
              nxt_skip = sum[4];
            end
          end
          else if (rom_data[7:4] == 4'h7)
          begin
            ram_we = 1'b1;
            ram_wd = rom_data[3:0];
            nxt_digit = digit_pointer_ff + 4'h1;
          end
          else if (is_lbi)
          begin
            nxt_row = rom_data[5:4];
            nxt_digit = rom_data[3:0] + 4'h1;
          end
          else if (rom_data[7:6] == 2'b00 && rom_data[3:0] == nme_pkg::NIB_LD)
          begin
            nxt_acc = ram_rd;
            nxt_row = row_pointer_ff ^ rom_data[5:4];
          end
          else if (rom_data[7:6] == 2'b00 && rom_data[3:0] inside {nme_pkg::NIB_X,
                   nme_pkg::NIB_XDS, nme_pkg::NIB_XIS})
          begin
            nxt_acc = ram_rd;
            ram_we = 1'b1;
            ram_wd = acc_ff;
            nxt_row = row_pointer_ff ^ rom_data[5:4];
            if (rom_data[3:0] == nme_pkg::NIB_XDS)
            begin
              nxt_digit = digit_pointer_ff - 4'h1;
              nxt_skip = (digit_pointer_ff == 4'h0);
            end
            else if (rom_data[3:0] == nme_pkg::NIB_XIS)
            begin
              nxt_digit = digit_pointer_ff + 4'h1;
              nxt_skip = (digit_pointer_ff == 4'hF);
            end
          end
          else
          begin
            unique case (rom_data)
              nme_pkg::OP_ASC:
              begin
                sum = {1'b0, acc_ff} + {1'b0, ram_rd} + {4'h0, carry_ff};
                nxt_acc = sum[3:0];
                nxt_carry = sum[4];
                nxt_skip = sum[4];
              end
              nme_pkg::OP_ADD: nxt_acc = acc_ff + ram_rd;
              nme_pkg::OP_XOR: nxt_acc = acc_ff ^ ram_rd;
              nme_pkg::OP_CLEAR_ACC: nxt_acc = 4'h0;
              nme_pkg::OP_COMP: nxt_acc = ~acc_ff;
              nme_pkg::OP_RC: nxt_carry = 1'b0;
              nme_pkg::OP_SC: nxt_carry = 1'b1;
              nme_pkg::OP_SKC: nxt_skip = carry_ff;
              nme_pkg::OP_SKE: nxt_skip = (acc_ff == ram_rd);
              nme_pkg::OP_CBA: nxt_acc = digit_pointer_ff;
              nme_pkg::OP_RET, nme_pkg::OP_RETSKIP:
              begin
                nxt_pc = return_slot_first_ff;
                nxt_sa = return_slot_second_ff;
                nxt_skip = rom_data[0];
              end
              nme_pkg::OP_XCHS:
              begin
                nxt_acc = shift_counter_reg_ff;
                nxt_sio = acc_ff;
                nxt_skl = carry_ff;
              end
              nme_pkg::OP_BR0, nme_pkg::OP_BR1, nme_pkg::OP_BR2, nme_pkg::OP_BR3,
              nme_pkg::OP_BS0, nme_pkg::OP_BS1, nme_pkg::OP_BS2, nme_pkg::OP_BS3:
              begin
                ram_we = 1'b1;
                ram_wd = ram_rd;
                unique case (rom_data)
                  nme_pkg::OP_BR0: ram_wd[0] = 1'b0;
                  nme_pkg::OP_BR1: ram_wd[1] = 1'b0;
                  nme_pkg::OP_BR2: ram_wd[2] = 1'b0;
                  nme_pkg::OP_BR3: ram_wd[3] = 1'b0;
                  nme_pkg::OP_BS0: ram_wd[0] = 1'b1;
                  nme_pkg::OP_BS1: ram_wd[1] = 1'b1;
                  nme_pkg::OP_BS2: ram_wd[2] = 1'b1;
                  default: ram_wd[3] = 1'b1;
                endcase
              end
              default: nxt_acc = acc_ff;
            endcase
          end
        end
      endcase
    end
  end

  // Register every piece of processor state except the divider and the RAM on the clock.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_ff <= S_FETCH;
      program_counter_ff <= nme_pkg::PC_RESET;
      return_slot_first_ff <= 9'h000;
      return_slot_second_ff <= 9'h000;
      acc_ff <= nme_pkg::ACC_RESET;
      carry_ff <= 1'b0;
      row_pointer_ff <= 2'h0;
      digit_pointer_ff <= 4'h0;
      en_ff <= nme_pkg::EN_RESET;
      gpo_ff <= nme_pkg::GPO_RESET;
      q_ff <= 8'h00;
      shift_counter_reg_ff <= 4'h0;
      clock_out_latch_ff <= 1'b1;
      skip_ff <= 1'b0;
      lbi_ff <= 1'b0;
      op1_ff <= 8'h00;
      si_prev_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      program_counter_ff <= nxt_pc;
      return_slot_first_ff <= nxt_sa;
      return_slot_second_ff <= nxt_sb;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      row_pointer_ff <= nxt_row;
      digit_pointer_ff <= nxt_digit;
      en_ff <= nxt_en;
      gpo_ff <= nxt_gpo;
      q_ff <= nxt_q;
      shift_counter_reg_ff <= nxt_sio;
      clock_out_latch_ff <= nxt_skl;
      skip_ff <= nxt_skip;
      lbi_ff <= nxt_lbi;
      op1_ff <= nxt_op1;
      si_prev_ff <= nxt_si_prev;
    end
  end

  // Pins: clock output is a gated half-cycle sync in shift mode.
  assign gport_out = gpo_ff;
  assign lport_out = q_ff;
  assign lport_oe = {8{en_ff[2]}};
  assign serial_out = en_ff[0] ? en_ff[3] : (en_ff[3] & shift_counter_reg_ff[3]);
  assign clock_out_pin = en_ff[0] ? clock_out_latch_ff :
                         (clock_out_latch_ff & (div_ff < 16'(CYC_CLKS / 2)));
  assign halted = (state_ff == S_HALT);
endmodule

// >>> rtl/nme_pkg.sv
// Package with opcodes, widths and reset values for the nibble processor core.
package nme_pkg;
  // Instruction cycle is a fixed divide of the 25 MHz clock.
  localparam int CLK_HZ = 25000000;
  localparam int ICYC_NS = 16000;
  localparam int ICYC_CLKS = (ICYC_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam logic [3:0] GPO_RESET = 4'h0;
  localparam logic [2:0] SUBPAGE = 3'h2;
  localparam logic [1:0] FIX_ROW = 2'h3;
  localparam logic [3:0] FIX_DIGIT = 4'hF;
  // First-byte opcodes; OP_PFX and OP_XAD take a second byte.
  localparam logic [7:0] OP_CLEAR_ACC = 8'h00;
  localparam logic [7:0] OP_XOR = 8'h02;
  localparam logic [7:0] OP_SKC = 8'h20;
  localparam logic [7:0] OP_SKE = 8'h21;
  localparam logic [7:0] OP_SC = 8'h22;
  localparam logic [7:0] OP_XAD = 8'h23;
  localparam logic [7:0] OP_ASC = 8'h30;
  localparam logic [7:0] OP_ADD = 8'h31;
  localparam logic [7:0] OP_RC = 8'h32;
  localparam logic [7:0] OP_PFX = 8'h33;
  localparam logic [7:0] OP_COMP = 8'h40;
  localparam logic [7:0] OP_RET = 8'h48;
  localparam logic [7:0] OP_RETSKIP = 8'h49;
  localparam logic [7:0] OP_XCHS = 8'h4F;
  localparam logic [7:0] OP_CAB = 8'h50;
  localparam logic [7:0] OP_CBA = 8'h4E;
  localparam logic [7:0] OP_LQ = 8'hBF;
  localparam logic [7:0] OP_IJ = 8'hFF;
  localparam logic [7:0] OP_BR0 = 8'h4C;
  localparam logic [7:0] OP_BR1 = 8'h45;
  localparam logic [7:0] OP_BR2 = 8'h42;
  localparam logic [7:0] OP_BR3 = 8'h43;
  localparam logic [7:0] OP_BS0 = 8'h4D;
  localparam logic [7:0] OP_BS1 = 8'h47;
  localparam logic [7:0] OP_BS2 = 8'h46;
  localparam logic [7:0] OP_BS3 = 8'h4B;
  // Second bytes after the prefix.
  localparam logic [7:0] P2_HALT = 8'h38;
  localparam logic [7:0] P2_TOQ = 8'h3C;
  localparam logic [7:0] P2_FROMQ = 8'h2C;
  localparam logic [7:0] P2_GZERO = 8'h21;
  localparam logic [7:0] P2_ING = 8'h2A;
  localparam logic [7:0] P2_INL = 8'h2E;
  localparam logic [7:0] P2_OMG = 8'h3A;
  localparam logic [3:0] P2_LEI_HI = 4'h6;
  // Pattern nibbles.
  localparam logic [3:0] NIB_ADD_IMM_SKIP = 4'h5;
  localparam logic [3:0] NIB_JMP = 4'h6;
  localparam logic [3:0] NIB_LD = 4'h5;
  localparam logic [3:0] NIB_X = 4'h6;
  localparam logic [3:0] NIB_XDS = 4'h7;
  localparam logic [3:0] NIB_XIS = 4'h4;
endpackage

// >>> rtl/nme_ram.sv
// Flip-flop data memory of nibbles, addressed by row and digit pointer.
`timescale 1ns/100ps
module nme_ram #(
  parameter int ROWS = 4
) (
  // Clock and write port.
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [3:0] wr_data,
  // Read port.
  input wire logic [5:0] rd_addr,
  output logic [3:0] rd_data
);
  logic [3:0] mem_ff [ROWS*16];
  logic [3:0] nxt_mem [ROWS*16];

  initial
  begin
    if (ROWS < 1 || ROWS > 4)
    begin
      $error("nme_ram: ROWS out of range");
    end
  end

  // Contents are not cleared at reset, matching the device.
  generate
    for (genvar i = 0; i < ROWS*16; i++)
    begin : g_cell
      always_comb
      begin
        nxt_mem[i] = (wr_en && wr_addr == 6'(i)) ? wr_data : mem_ff[i];
      end
      always_ff @(posedge clock)
      begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  endgenerate

  assign rd_data = mem_ff[rd_addr[$clog2(ROWS*16)-1:0]];
endmodule

// >>> verification/nme_core_props.sv
// Port checker of the nibble processor core.
`timescale 1ns/100ps
module nme_core_props #(
  parameter int CYC_CLKS = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Program memory.
  input wire logic [8:0] rom_addr,
  input wire logic [7:0] rom_data,
  // Ports.
  input wire logic [3:0] gport_in,
  input wire logic [3:0] gport_out,
  input wire logic [7:0] lport_in,
  input wire logic [7:0] lport_out,
  input wire logic [7:0] lport_oe,
  // Serial and status.
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic clock_out_pin,
  input wire logic halted
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // Steps of a halted core: it stays asleep and its address, general and byte port outputs and byte port enables hold.
  sequence s_asleep;
    halted [*2];
  endsequence
  sequence s_frozen;
    $stable(rom_addr) && $stable(lport_out) && $stable(gport_out) && $stable(lport_oe);
  endsequence
  // The reset-clear check carries its own disable, since the reset is its cause.
  a_reset_clears_out: assert property (disable iff (1'b0)
    reset |=> !halted && lport_oe == 8'h00 && lport_out == 8'h00 && gport_out == 4'h0)
    else $error("outputs not cleared by reset");
  a_first_fetch: assert property ($fell(reset) |-> (rom_addr == nme_pkg::PC_RESET) [*3])
    else $error("first fetch not from address zero");
  // Only a reset may wake a halted core.
  a_halt_sticky: assert property (halted |=> s_asleep)
    else $error("halted dropped without reset");
  a_halt_frozen: assert property (halted |=> s_frozen)
    else $error("outputs moved while halted");
  // The byte port drivers switch together from one enable bit.
  a_oe_uniform: assert property (lport_oe == 8'h00 || lport_oe == 8'hFF)
    else $error("byte port enables disagree");
  a_oe_holds: assert property ($changed(lport_oe) |-> ##1 $stable(lport_oe) ##1 $stable(lport_oe))
    else $error("byte port enable changed within one instruction");
  // State moves only on instruction ticks, so a new output value stands a whole cycle.
  a_gport_holds: assert property ($changed(gport_out) |=> $stable(gport_out) [*3])
    else $error("general port changed twice within one instruction");
  a_lport_holds: assert property ($changed(lport_out) |=> $stable(lport_out) [*3])
    else $error("byte port latch changed twice within one instruction");
endmodule

bind nme_core nme_core_props #(.CYC_CLKS(CYC_CLKS)) u_props (.clock(clock), .reset(reset),
  .rom_addr(rom_addr), .rom_data(rom_data), .gport_in(gport_in), .gport_out(gport_out),
  .lport_in(lport_in), .lport_out(lport_out), .lport_oe(lport_oe), .serial_in(serial_in),
  .serial_out(serial_out), .clock_out_pin(clock_out_pin), .halted(halted));

// >>> verification/nme_core_tb_top.sv
// Self-checking bench of the nibble processor core.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module nme_core_tb_top;
  // A short instruction cycle keeps the run brief; the ceiling cuts a hang.
  localparam int CYC = 4;
  localparam int LIMIT = 40000;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [8:0] rom_addr;
  logic [7:0] rom_data;
  logic [3:0] gport_in = 4'h0;
  logic [3:0] gport_out;
  logic [7:0] lport_in = 8'h00;
  logic [7:0] lport_out;
  logic [7:0] lport_oe;
  logic serial_in = 1'b0;
  logic serial_out;
  logic clock_out_pin;
  logic halted;
  logic [7:0] rom [512];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] ops [21] = '{8'h30, 8'h31, 8'h02, 8'h00, 8'h40, 8'h32, 8'h22, 8'h21, 8'h20,
    8'h05, 8'h06, 8'h07, 8'h04, 8'h4C, 8'h45, 8'h42, 8'h43, 8'h4D, 8'h47, 8'h46, 8'h4B};

  nme_core #(.CYC_CLKS(CYC)) dut (.clock(clock), .reset(reset), .rom_addr(rom_addr),
    .rom_data(rom_data), .gport_in(gport_in), .gport_out(gport_out), .lport_in(lport_in),
    .lport_out(lport_out), .lport_oe(lport_oe), .serial_in(serial_in),
    .serial_out(serial_out), .clock_out_pin(clock_out_pin), .halted(halted));

  // Clock of 40 ns period.
  always #20 clock = ~clock;
  // Program memory answers at once, as the core expects.
  assign rom_data = rom[rom_addr];
  // Port inputs wander at random, changed away from the sampling edge.
  always @(negedge clock)
  begin
    gport_in <= 4'($urandom);
    lport_in <= 8'($urandom);
    serial_in <= 1'($urandom);
  end
  // Cycle ceiling against a hung run.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fail_count++;
      end_sim();
    end
  end

  // Result of one operation: skip, carry, accumulator and RAM nibble.
  function automatic logic [9:0] exp_alu(input logic [7:0] op, input logic [3:0] a,
      input logic [3:0] m, input logic c);
    logic [4:0] s;
    logic [4:0] y;
    logic [3:0] ea;
    logic [3:0] em;
    logic ec;
    logic sk;
    s = {1'b0, a} + {1'b0, m} + {4'h0, c};
    y = {1'b0, a} + {1'b0, op[3:0]};
    case (op)
      8'h30: ea = s[3:0];
      8'h31: ea = a + m;
      8'h02: ea = a ^ m;
      8'h00: ea = 4'h0;
      8'h40: ea = ~a;
      8'h05, 8'h06, 8'h07, 8'h04: ea = m;
      default: ea = (op[7:4] == 4'h5) ? y[3:0] : a;
    endcase
    case (op)
      8'h06, 8'h07, 8'h04: em = a;
      8'h4C: em = m & 4'hE;
      8'h45: em = m & 4'hD;
      8'h42: em = m & 4'hB;
      8'h43: em = m & 4'h7;
      8'h4D: em = m | 4'h1;
      8'h47: em = m | 4'h2;
      8'h46: em = m | 4'h4;
      8'h4B: em = m | 4'h8;
      default: em = m;
    endcase
    ec = (op == 8'h30) ? s[4] : (op == 8'h32) ? 1'b0 : (op == 8'h22) ? 1'b1 : c;
    sk = (op == 8'h30) ? s[4] : (op == 8'h21) ? (a == m) : (op == 8'h20) ? c :
      (op == 8'h07) ? 1'b1 : (op[7:4] == 4'h5) ? y[4] : 1'b0;
    return {sk, ec, ea, em};
  endfunction

  // Restart the core on the loaded program and wait for it to halt.
  task automatic go();
    int n;
    @(negedge clock);
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    `CHK("halted_reset", 1'b0, halted)
    n = 0;
    while (halted !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    `CHK("halted", 1'b1, halted)
  endtask

  // Seed RAM and accumulator, run one operation, then show A, RAM and carry at the ports.
  // A complement follows the operation so that a skip shows up in the accumulator.
  task automatic alu(input logic [7:0] op, input logic [3:0] a, input logic [3:0] m,
      input logic c);
    logic [9:0] e;
    logic [3:0] fa;
    logic [7:0] p[$];
    e = exp_alu(op, a, m, c);
    fa = e[9] ? e[7:4] : ~e[7:4];
    p = '{8'h00, 8'h0F};
    if (m != 4'h0) p.push_back({4'h5, m});
    p = {p, 8'h06, 8'h00};
    if (a != 4'h0) p.push_back({4'h5, a});
    p = {p, c ? 8'h22 : 8'h32, op, 8'h40, 8'h33, 8'h64, 8'h33, 8'h3C, 8'h20, 8'h33, 8'h3A};
    p = {p, 8'h33, 8'h38};
    foreach (rom[i]) rom[i] = 8'h00;
    foreach (p[i]) rom[i] = p[i];
    go();
    `CHK("acc", fa, lport_out[7:4])
    `CHK("port_enable", 8'hFF, lport_oe)
    // The digit-stepping swaps leave the pointer on an unwritten nibble.
    if (op != 8'h07 && op != 8'h04)
    begin
      `CHK("ram", e[3:0], lport_out[3:0])
      `CHK("carry", e[8] ? 4'h0 : e[3:0], gport_out)
    end
    $display("test op %h done", op);
  endtask

  // Calls, returns with skip, page-pair jump, pointer-load chain, table fetch, indirect jump.
  task automatic jumps();
    logic [7:0] p[$];
    foreach (rom[i]) rom[i] = 8'h00;
    p = '{8'h00, 8'h1F, 8'h55, 8'h06, 8'h00, 8'h0F, 8'h06, 8'h00, 8'h0F, 8'h1F, 8'h81};
    p = {p, 8'h52, 8'h84, 8'h33, 8'h64, 8'hBF, 8'hFF, 8'h5F};
    foreach (p[i]) rom[i] = p[i];
    rom[9'h081] = 8'h51;
    rom[9'h082] = 8'h49;
    rom[9'h084] = 8'hC5;
    rom[9'h0C5] = 8'h52;
    rom[9'h0C6] = 8'h48;
    rom[9'h030] = 8'h40;
    rom[9'h040] = 8'h33;
    rom[9'h041] = 8'h38;
    go();
    `CHK("table_byte", 8'h40, lport_out)
    `CHK("gport_idle", 4'h0, gport_out)
    repeat (40) @(negedge clock);
    `CHK("still_halted", 1'b1, halted)
    `CHK("latch_kept", 8'h40, lport_out)
    $display("test jumps done");
  endtask

  // Round trip through the fixed nibble, then the clock latch and data pin in counter mode.
  // Counter mode is used, so the half-cycle clock duty of shift mode is not owed here.
  task automatic serial_xad();
    logic [7:0] p[$];
    foreach (rom[i]) rom[i] = 8'h00;
    p = '{8'h00, 8'h57, 8'h23, 8'hBF, 8'h00, 8'h23, 8'hBF, 8'h33, 8'h3C, 8'h22};
    p = {p, 8'h33, 8'h69, 8'h4F, 8'h32, 8'h4F, 8'h33, 8'h38};
    foreach (p[i]) rom[i] = p[i];
    go();
    `CHK("fixed_ram", 4'h7, lport_out[7:4])
    `CHK("serial_out", 1'b1, serial_out)
    `CHK("clock_out", 1'b0, clock_out_pin)
    $display("test serial done");
  endtask

  // Print the counts and the verdict, then stop.
  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Corner rounds (all ones, all zeros) first, then random operands and immediates.
  initial
  begin
    void'($urandom(32'h7EDF));
    for (int r = 0; r < 4; r++)
    begin
      foreach (ops[i])
      begin
        if (r < 2)
          alu(ops[i], {4{r == 0}}, {4{r == 0}}, r == 0);
        else
          alu(ops[i], 4'($urandom), 4'($urandom), 1'($urandom));
      end
    end
    repeat (8) alu({4'h5, 4'($urandom_range(15, 1))}, 4'($urandom), 4'($urandom), 1'b0);
    serial_xad();
    jumps();
    end_sim();
  end
endmodule
